// ===== rtl/gslt_pkg.sv
// Shared constants for the guarded serial loop transfer
package gslt_pkg;
   // Timing
   localparam int CLK_HZ     = 10_000_000;
   localparam int SHIFT_HZ   = 256_000;
   localparam int SHIFT_HALF = CLK_HZ / (2 * SHIFT_HZ);
   localparam int CLEAR_MS   = 8;
   localparam int CLEAR_CYC  = CLEAR_MS * (CLK_HZ / 1000);
   localparam int STROBE_CYC = 2 * SHIFT_HALF;
   // Loop geometry
   localparam int BURST_BITS   = 24;
   localparam int CTRL_BITS    = 48;
   localparam int STAT_BITS    = 16;
   localparam int LOOP_BITS    = CTRL_BITS + STAT_BITS;
   localparam int SHIFTS       = 5;
   localparam int STROBE_AFTER = 2;
   localparam int MAX_ATTEMPTS = 3;
   // Programming byte fields (write with register select low)
   localparam int PROG_TRIG_BIT    = 0;
   localparam int PROG_RESTART_BIT = 1;
   // Adaptor status byte fields (read with register select low)
   localparam int AST_BUSY_BIT  = 0;
   localparam int AST_CLEAR_BIT = 1;
   localparam int AST_RXCNT_LSB = 2;
   localparam int AST_TXCNT_LSB = 4;
   // Controller APB map
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_DATA_LO = 8'h04;
   localparam logic [7:0] REG_DATA_HI = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h0C;
   localparam int CTRL_GO_BIT  = 0;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_DONE_BIT  = 1;
   localparam int ST_FAIL_BIT  = 2;
   localparam int ST_TRIG_BIT  = 3;
   localparam int ST_ATT_LSB   = 4;
   localparam int ST_STAT_LSB  = 16;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
endpackage

// ===== rtl/gslt_if.sv
// Byte bus between loop controller and serial adaptor
`timescale 1ns/1ns
interface gslt_if;
   logic       req;
   logic       wr;
   logic       a0;
   logic [7:0] wdata;
   logic       loop_shift_trigger;
   logic       ack;
   logic [7:0] rdata;
   logic       busy;
   logic       power_up_clear_n;

   modport host (output req, wr, a0, wdata, loop_shift_trigger,
                 input  ack, rdata, busy, power_up_clear_n);
   modport dev  (input  req, wr, a0, wdata, loop_shift_trigger,
                 output ack, rdata, busy, power_up_clear_n);
endinterface

// ===== rtl/gslt_device.sv
// Serial adaptor, burst clock generator and in-guard shift loop
`timescale 1ns/1ns
module gslt_device #(
   parameter int CLEAR_CYC = gslt_pkg::CLEAR_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Controller side
   gslt_if.dev              bus,
   // Analog side
   input  wire logic [15:0] status_in,
   input  wire logic        external_clear_request,
   output logic      [47:0] control_out,
   output logic             strobe,
   output logic             trigger_enable,
   output logic             power_up_clear_n
);
   localparam int H  = gslt_pkg::SHIFT_HALF;
   localparam int LB = gslt_pkg::LOOP_BITS;
   localparam int CW = $clog2(CLEAR_CYC + 1);
   localparam int SW = $clog2(gslt_pkg::STROBE_CYC + 1);

   typedef enum logic [1:0] {B_IDLE, B_ARM, B_PERMIT, B_SHIFT} gslt_burst_e;

   gslt_burst_e  bst_q;
   logic [5:0]   div_q;
   logic         ext_s1_q, ext_s2_q;
   logic [15:0]  st_s1_q, st_s2_q;
   logic [CW-1:0] clr_cnt_q;
   logic         clear_n_q;
   logic [7:0]   tx_mem_q [3];
   logic [1:0]   tx_cnt_q;
   logic [23:0]  tx_word_q;
   logic         tx_bit_q;
   logic [4:0]   bit_cnt_q;
   logic [LB-1:0] loop_q;
   logic [23:0]  rx_sh_q;
   logic [7:0]   rx_mem_q [3];
   logic [1:0]   rx_cnt_q;
   logic [1:0]   rd_ptr_q;
   logic [2:0]   burst_no_q;
   logic [SW-1:0] strb_cnt_q;
   logic         trig_q, busy_q, ack_q, strobe_q;
   logic [7:0]   rdata_q;
   logic [47:0]  ctl_q;

   logic tick_rx, tick_sh, clr, accept, shift_now, last_bit;
   logic fifo_wr, fifo_rd, prog_wr, restart;
   logic [23:0] rx_next;

   assign clr       = !clear_n_q;
   // Inverted shift clock rises where the transmit clock falls
   assign tick_rx   = (div_q == 6'(H - 1));
   assign tick_sh   = (div_q == 6'(2 * H - 1));
   assign accept    = bus.loop_shift_trigger && !clr && bst_q == B_IDLE
                      && strb_cnt_q == '0;
   assign shift_now = (bst_q == B_SHIFT) && tick_sh;
   assign last_bit  = shift_now && bit_cnt_q == 5'(gslt_pkg::BURST_BITS - 1);
   assign rx_next   = {loop_q[0], rx_sh_q[23:1]};
   assign fifo_wr   = bus.req && bus.wr && bus.a0 && !clr;
   assign prog_wr   = bus.req && bus.wr && !bus.a0 && !clr;
   assign fifo_rd   = bus.req && !bus.wr && bus.a0;
   assign restart   = prog_wr && bus.wdata[gslt_pkg::PROG_RESTART_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Power-up clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         st_s1_q  <= '0;
         st_s2_q  <= '0;
      end
      else
      begin
         ext_s1_q <= external_clear_request;
         ext_s2_q <= ext_s1_q;
         st_s1_q  <= status_in;
         st_s2_q  <= st_s1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clr_cnt_q <= '0;
         clear_n_q <= 1'b0;
      end
      else if (ext_s2_q)
      begin
         clr_cnt_q <= '0;
         clear_n_q <= 1'b0;
      end
      else if (clr)
      begin
         if (clr_cnt_q == CW'(CLEAR_CYC - 1))
            clear_n_q <= 1'b1;
         else
            clr_cnt_q <= clr_cnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Burst clock generator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= '0;
      else if (div_q == 6'(2 * H - 1))
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   // Permit low in PERMIT and SHIFT covers both directions at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bst_q     <= B_IDLE;
         bit_cnt_q <= '0;
         tx_bit_q  <= 1'b0;
      end
      else if (clr)
      begin
         bst_q     <= B_IDLE;
         bit_cnt_q <= '0;
         tx_bit_q  <= 1'b0;
      end
      else
      begin
         case (bst_q)
            B_IDLE:
               if (accept)
                  bst_q <= B_ARM;
            B_ARM:
               if (tick_rx)
                  bst_q <= B_PERMIT;
            B_PERMIT:
               if (tick_rx)
               begin
                  bst_q    <= B_SHIFT;
                  tx_bit_q <= tx_word_q[0];
               end
            B_SHIFT:
            begin
               if (tick_rx)
                  tx_bit_q <= tx_word_q[bit_cnt_q];
               if (shift_now)
                  bit_cnt_q <= bit_cnt_q + 1'b1;
               if (last_bit)
               begin
                  bst_q     <= B_IDLE;
                  bit_cnt_q <= '0;
               end
            end
            default:
               bst_q <= B_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit FIFO
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_cnt_q  <= '0;
         tx_word_q <= '0;
         for (int i = 0; i < 3; i++)
            tx_mem_q[i] <= '0;
      end
      else if (clr)
      begin
         tx_cnt_q <= '0;
         for (int i = 0; i < 3; i++)
            tx_mem_q[i] <= '0;
      end
      else if (bst_q == B_ARM && tick_rx)
      begin
         // Byte one leaves first, least significant bit first
         tx_word_q <= {tx_mem_q[2], tx_mem_q[1], tx_mem_q[0]};
         tx_cnt_q  <= '0;
         for (int i = 0; i < 3; i++)
            tx_mem_q[i] <= '0;
      end
      else if (fifo_wr && tx_cnt_q != 2'd3)
      begin
         tx_mem_q[tx_cnt_q] <= bus.wdata;
         tx_cnt_q           <= tx_cnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift loop: control chain in the upper bits, status chain below
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         loop_q  <= '0;
         rx_sh_q <= '0;
      end
      else if (clr)
         loop_q <= '0;
      else if (shift_now)
      begin
         rx_sh_q <= rx_next;
         loop_q  <= {tx_bit_q, loop_q[LB-1:1]};
      end
      else if (strb_cnt_q != '0)
         loop_q[gslt_pkg::STAT_BITS-1:0] <= st_s2_q;
   end

   // Outputs copy the chain only while the internal latch enable is high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_q <= '0;
      else if (clr || strb_cnt_q != '0)
         ctl_q <= loop_q[LB-1:gslt_pkg::STAT_BITS];
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe sequencing and programming byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         burst_no_q <= '0;
         strb_cnt_q <= '0;
         trig_q     <= 1'b0;
      end
      else if (clr)
      begin
         burst_no_q <= '0;
         strb_cnt_q <= '0;
         trig_q     <= 1'b0;
      end
      else
      begin
         if (strb_cnt_q != '0)
            strb_cnt_q <= strb_cnt_q - 1'b1;
         if (last_bit)
         begin
            if (burst_no_q == 3'(gslt_pkg::STROBE_AFTER - 1))
               strb_cnt_q <= SW'(gslt_pkg::STROBE_CYC);
            burst_no_q <= (burst_no_q == 3'(gslt_pkg::SHIFTS - 1)) ? '0
                          : burst_no_q + 1'b1;
         end
         if (prog_wr)
            trig_q <= bus.wdata[gslt_pkg::PROG_TRIG_BIT];
         if (restart)
         begin
            burst_no_q <= '0;
            strb_cnt_q <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive holding bytes and bus answers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_cnt_q <= '0;
         rd_ptr_q <= '0;
         for (int i = 0; i < 3; i++)
            rx_mem_q[i] <= '0;
      end
      else if (clr)
      begin
         rx_cnt_q <= '0;
         rd_ptr_q <= '0;
         for (int i = 0; i < 3; i++)
            rx_mem_q[i] <= '0;
      end
      else if (last_bit)
      begin
         // Unread old bytes are overwritten by the new word
         rx_mem_q[0] <= rx_next[7:0];
         rx_mem_q[1] <= rx_next[15:8];
         rx_mem_q[2] <= rx_next[23:16];
         rx_cnt_q    <= 2'd3;
         rd_ptr_q    <= '0;
      end
      else if (fifo_rd && rx_cnt_q != '0)
      begin
         rx_mem_q[rd_ptr_q] <= '0;
         rx_cnt_q           <= rx_cnt_q - 1'b1;
         rd_ptr_q           <= rd_ptr_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
         busy_q  <= 1'b0;
      end
      else
      begin
         ack_q  <= bus.req;
         busy_q <= accept || bst_q != B_IDLE || strb_cnt_q != '0;
         if (bus.req && !bus.wr)
         begin
            rdata_q <= '0;
            if (bus.a0)
               rdata_q <= (rx_cnt_q != '0) ? rx_mem_q[rd_ptr_q] : 8'h00;
            else
            begin
               rdata_q[gslt_pkg::AST_BUSY_BIT]  <= busy_q;
               rdata_q[gslt_pkg::AST_CLEAR_BIT] <= clr;
               rdata_q[gslt_pkg::AST_RXCNT_LSB +: 2] <= rx_cnt_q;
               rdata_q[gslt_pkg::AST_TXCNT_LSB +: 2] <= tx_cnt_q;
            end
         end
      end
   end

   // Registered pin; lags the internal latch enable by one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         strobe_q <= 1'b1;
      else
         strobe_q <= clr || strb_cnt_q != '0;
   end

   assign bus.ack              = ack_q;
   assign bus.rdata            = rdata_q;
   assign bus.busy             = busy_q;
   assign bus.power_up_clear_n = clear_n_q;
   assign control_out          = ctl_q;
   assign strobe               = strobe_q;
   assign trigger_enable       = trig_q;
   assign power_up_clear_n     = clear_n_q;
endmodule

// ===== rtl/gslt_host.sv
// Loop transfer controller with APB registers
`timescale 1ns/1ns
module gslt_host (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Adaptor side
   gslt_if.host             bus,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef enum logic [3:0] {H_IDLE, H_PROG, H_LOAD, H_FIRE, H_WBUSY, H_WIDLE,
                             H_READ, H_CHECK, H_FINAL} gslt_host_e;

   gslt_host_e  st_q;
   logic [31:0] lo_q, prdata_q;
   logic [15:0] hi_q, status_q;
   logic        pready_q, pslverr_q, go_q;
   logic [2:0]  burst_q;
   logic [1:0]  idx_q, att_q;
   logic [3:0]  rd_q;
   logic        err_q, pend_q, trig_q, done_q, fail_q;
   logic        req_q, wr_q, a0_q, start_q;
   logic [7:0]  wdata_q;
   logic        acc, mapped;
   logic [31:0] stat_word;
   logic [47:0] ctl;

   function automatic logic [7:0] ctl_byte(input logic [47:0] c, input logic [2:0] i);
      ctl_byte = c[8*i +: 8];
   endfunction

   // Bytes for each burst: new 1-3, new 4-6, dummy, then again
   function automatic logic [7:0] tx_byte(input logic [47:0] c, input logic [2:0] b,
                                          input logic [1:0] i);
      case (b)
         3'd1, 3'd4: tx_byte = ctl_byte(c, 3'(i));
         3'd2, 3'd5: tx_byte = ctl_byte(c, 3'(i) + 3'd3);
         default:    tx_byte = 8'h00;
      endcase
   endfunction

   assign ctl    = {hi_q, lo_q};
   assign acc    = psel && penable && pready_q;
   assign mapped = paddr == gslt_pkg::REG_CTRL || paddr == gslt_pkg::REG_DATA_LO
                   || paddr == gslt_pkg::REG_DATA_HI || paddr == gslt_pkg::REG_STATUS;

   always_comb
   begin
      stat_word = '0;
      stat_word[gslt_pkg::ST_BUSY_BIT] = st_q != H_IDLE;
      stat_word[gslt_pkg::ST_DONE_BIT] = done_q;
      stat_word[gslt_pkg::ST_FAIL_BIT] = fail_q;
      stat_word[gslt_pkg::ST_TRIG_BIT] = trig_q;
      stat_word[gslt_pkg::ST_ATT_LSB +: 2] = att_q;
      stat_word[gslt_pkg::ST_STAT_LSB +: 16] = status_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         lo_q      <= gslt_pkg::DATA_RESET;
         hi_q      <= gslt_pkg::DATA_RESET[15:0];
         go_q      <= 1'b0;
      end
      else
      begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         go_q      <= 1'b0;
         if (psel && penable && !pready_q)
            prdata_q <= (paddr == gslt_pkg::REG_DATA_LO) ? lo_q
                      : (paddr == gslt_pkg::REG_DATA_HI) ? {16'h0000, hi_q}
                      : (paddr == gslt_pkg::REG_STATUS)  ? stat_word : 32'h0000_0000;
         if (acc && pwrite)
         begin
            if (paddr == gslt_pkg::REG_DATA_LO)
               lo_q <= pwdata;
            if (paddr == gslt_pkg::REG_DATA_HI)
               hi_q <= pwdata[15:0];
            if (paddr == gslt_pkg::REG_CTRL)
               go_q <= pwdata[gslt_pkg::CTRL_GO_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= H_IDLE;
         {burst_q, idx_q, att_q, rd_q} <= '0;
         {err_q, pend_q, trig_q, done_q, fail_q} <= '0;
         {req_q, wr_q, a0_q, start_q} <= '0;
         wdata_q  <= '0;
         status_q <= '0;
      end
      else
      begin
         req_q   <= 1'b0;
         start_q <= 1'b0;
         case (st_q)
            H_IDLE:
               if (go_q && bus.power_up_clear_n)
               begin
                  att_q  <= '0;
                  done_q <= 1'b0;
                  fail_q <= 1'b0;
                  st_q   <= H_PROG;
               end
            H_PROG, H_FINAL:
               if (!pend_q)
               begin
                  {req_q, wr_q, a0_q, pend_q} <= 4'b1101;
                  wdata_q <= '0;
                  wdata_q[gslt_pkg::PROG_TRIG_BIT]    <= trig_q;
                  wdata_q[gslt_pkg::PROG_RESTART_BIT] <= st_q == H_PROG;
               end
               else if (bus.ack)
               begin
                  pend_q <= 1'b0;
                  if (st_q == H_FINAL)
                  begin
                     done_q <= 1'b1;
                     st_q   <= H_IDLE;
                  end
                  else
                  begin
                     {burst_q, idx_q, rd_q, err_q} <= {3'd1, 2'd0, 4'd0, 1'b0};
                     st_q <= H_LOAD;
                  end
               end
            H_LOAD:
               if (!pend_q)
               begin
                  {req_q, wr_q, a0_q, pend_q} <= 4'b1111;
                  wdata_q <= tx_byte(ctl, burst_q, idx_q);
               end
               else if (bus.ack)
               begin
                  pend_q <= 1'b0;
                  idx_q  <= (idx_q == 2'd2) ? 2'd0 : idx_q + 1'b1;
                  if (idx_q == 2'd2)
                     st_q <= H_FIRE;
               end
            H_FIRE:
               if (!bus.busy)
               begin
                  start_q <= 1'b1;
                  st_q    <= H_WBUSY;
               end
            H_WBUSY:
               // A clear refuses the start; go on and let readback fail
               if (bus.busy || !bus.power_up_clear_n)
                  st_q <= H_WIDLE;
            H_WIDLE:
               if (!bus.busy)
               begin
                  if (burst_q >= 3'd3)
                     st_q <= H_READ;
                  else
                  begin
                     burst_q <= burst_q + 1'b1;
                     st_q    <= H_LOAD;
                  end
               end
            H_READ:
               if (!pend_q)
                  {req_q, wr_q, a0_q, pend_q} <= 4'b1011;
               else if (bus.ack)
               begin
                  pend_q <= 1'b0;
                  rd_q   <= rd_q + 1'b1;
                  if (rd_q == 4'd0)
                     status_q[7:0] <= bus.rdata;
                  if (rd_q == 4'd1)
                     status_q[15:8] <= bus.rdata;
                  if (rd_q >= 4'd2 && rd_q <= 4'd7
                      && bus.rdata != ctl_byte(ctl, 3'(rd_q - 4'd2)))
                     err_q <= 1'b1;
                  idx_q <= (idx_q == 2'd2) ? 2'd0 : idx_q + 1'b1;
                  if (idx_q == 2'd2)
                  begin
                     if (burst_q == 3'(gslt_pkg::SHIFTS))
                        st_q <= H_CHECK;
                     else
                     begin
                        burst_q <= burst_q + 1'b1;
                        st_q    <= H_LOAD;
                     end
                  end
               end
            H_CHECK:
               if (err_q && att_q != 2'(gslt_pkg::MAX_ATTEMPTS - 1))
               begin
                  att_q <= att_q + 1'b1;
                  st_q  <= H_PROG;
               end
               else
               begin
                  trig_q <= !err_q;
                  fail_q <= err_q;
                  st_q   <= H_FINAL;
               end
            default:
               st_q <= H_IDLE;
         endcase
      end
   end

   assign bus.req                = req_q;
   assign bus.wr                 = wr_q;
   assign bus.a0                 = a0_q;
   assign bus.wdata              = wdata_q;
   assign bus.loop_shift_trigger = start_q;
   assign prdata                 = prdata_q;
   assign pready                 = pready_q;
   assign pslverr                = pslverr_q;
endmodule

// ===== verif/gslt_sva.sv
// Checker for the controller-adaptor byte bus
`timescale 1ns/1ns
module gslt_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Byte bus
   input wire logic req,
   input wire logic ack,
   input wire logic loop_shift_trigger,
   input wire logic busy,
   input wire logic power_up_clear_n
);
   ////////////////////////////////////////
   logic [10:0] run_q;
   // Burst length in cycles, cleared while idle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         run_q <= 11'h000;
      else
         run_q <= busy ? run_q + 11'h001 : 11'h000;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_start;
      loop_shift_trigger && !busy && power_up_clear_n;
   endsequence
   sequence s_burst;
      busy [*8];
   endsequence
   property p_start_burst; s_start |=> s_burst; endproperty
   property p_busy_cause; $rose(busy) |-> $past(loop_shift_trigger); endproperty
   property p_burst_min; $fell(busy) |-> $past(run_q) >= 11'h390; endproperty
   property p_burst_max; run_q < 11'h47E; endproperty
   property p_ignore_start; busy && loop_shift_trigger |=> busy; endproperty
   property p_ack; req |=> ack; endproperty
   property p_ack_cause; ack |-> $past(req) && !req; endproperty
   property p_clear_idle; !power_up_clear_n |-> !busy && !loop_shift_trigger; endproperty
   a_start_burst: assert property (p_start_burst) else $error("no burst after start");
   a_busy_cause: assert property (p_busy_cause) else $error("burst without start");
   a_burst_min: assert property (p_burst_min) else $error("burst too short");
   a_burst_max: assert property (p_burst_max) else $error("burst too long");
   a_ignore_start: assert property (p_ignore_start) else $error("start broke burst");
   a_ack: assert property (p_ack) else $error("missing byte ack");
   a_ack_cause: assert property (p_ack_cause) else $error("stray byte ack");
   a_clear_idle: assert property (p_clear_idle) else $error("activity in clear");
endmodule

// ===== verif/guarded_serial_loop_transfer_test.sv
// Self-checking bench for the guarded serial loop transfer
`timescale 1ns/1ns
module guarded_serial_loop_transfer_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        ext_clr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, strobe, trig, clr_n;
   logic [15:0] stat_in = 16'hA53C;
   logic [47:0] ctl;
   int          fail_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n_start = 0;
   int          n_strobe = 0;
   always #50 pclk = ~pclk;
   // Starts and strobe pulses seen, for per-transfer counts
   always @(posedge pclk)
      if (u_gslt_if.loop_shift_trigger === 1'b1)
         n_start++;
   always @(posedge strobe)
      n_strobe++;
   ////////////////////////////////////////
   gslt_if u_gslt_if ();
   gslt_host u_gslt_host (.pclk(pclk), .presetn(presetn), .bus(u_gslt_if.host),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Short clear keeps the run brief
   gslt_device #(.CLEAR_CYC(50)) u_gslt_device (.pclk(pclk), .presetn(presetn),
      .bus(u_gslt_if.dev), .status_in(stat_in), .external_clear_request(ext_clr),
      .control_out(ctl), .strobe(strobe), .trigger_enable(trig), .power_up_clear_n(clr_n));
   gslt_sva u_gslt_sva (.pclk(pclk), .presetn(presetn), .req(u_gslt_if.req),
      .ack(u_gslt_if.ack), .loop_shift_trigger(u_gslt_if.loop_shift_trigger),
      .busy(u_gslt_if.busy), .power_up_clear_n(u_gslt_if.power_up_clear_n));
   ////////////////////////////////////////
   task automatic end_of_test;
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Full five-burst transfer; the second go lands while busy
   task automatic xfer(input logic [47:0] v);
      int s0;
      int s1;
      s0 = n_start;
      s1 = n_strobe;
      apb(1'b1, gslt_pkg::REG_DATA_LO, v[31:0]);
      apb(1'b1, gslt_pkg::REG_DATA_HI, {16'h0000, v[47:32]});
      apb(1'b0, gslt_pkg::REG_DATA_HI, 32'h0000_0000);
      chk("data_hi", {32'h0000_0000, v[47:32]}, {16'h0000, rd});
      apb(1'b1, gslt_pkg::REG_CTRL, 32'h0000_0001);
      apb(1'b1, gslt_pkg::REG_CTRL, 32'h0000_0001);
      do apb(1'b0, gslt_pkg::REG_STATUS, 32'h0000_0000); while (rd[1:0] !== 2'b10);
      chk("control_out", v, ctl);
      chk("status reg", {16'h0000, stat_in, 16'h000A}, {16'h0000, rd});
      chk("trigger_enable", 48'h1, {47'h0, trig});
      chk("strobe", 48'h0, {47'h0, strobe});
      chk("bursts", 48'h5, 48'(n_start - s0));
      chk("strobes", 48'h1, 48'(n_strobe - s1));
      chk("status bytes", {32'h0000_0000, stat_in}, {32'h0000_0000, rd[31:16]});
      chk("readback fail", 48'h0, {47'h0, rd[2]});
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge pclk);
      chk("strobe in reset", 48'h1, {47'h0, strobe});
      presetn <= 1'b1;
      repeat (40) @(posedge pclk);
      chk("clear early", 48'h0, {47'h0, clr_n});
      chk("strobe in clear", 48'h1, {47'h0, strobe});
      repeat (20) @(posedge pclk);
      chk("clear late", 48'h1, {47'h0, clr_n});
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped err", 48'h1, {47'h0, err});
      chk("unmapped data", 48'h0, {16'h0000, rd});
      xfer(48'hC3A5_0F1E_7788);
      stat_in <= 16'h5AC3;
      xfer(48'h1234_5678_9ABC);
      // Changing the word after the strobe forces one retry
      apb(1'b1, gslt_pkg::REG_DATA_LO, 32'h0F0F_3C3C);
      apb(1'b1, gslt_pkg::REG_CTRL, 32'h0000_0001);
      @(posedge strobe);
      apb(1'b1, gslt_pkg::REG_DATA_LO, 32'h5A5A_C3C3);
      do apb(1'b0, gslt_pkg::REG_STATUS, 32'h0000_0000); while (rd[1:0] !== 2'b10);
      chk("retry status", {16'h0000, stat_in, 16'h001A}, {16'h0000, rd});
      chk("retry control", {16'h1234, 32'h5A5A_C3C3}, ctl);
      ext_clr <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("ext clear", 48'h0, {47'h0, clr_n});
      chk("ext strobe", 48'h1, {47'h0, strobe});
      chk("ext trigger", 48'h0, {47'h0, trig});
      ext_clr <= 1'b0;
      repeat (70) @(posedge pclk);
      chk("ext clear end", 48'h1, {47'h0, clr_n});
      xfer(48'h0F1E_2D3C_4B5A);
      end_of_test;
   end
   // Five transfer attempts need about 25000 cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 50000)
      begin
         fail_count++;
         end_of_test;
      end
   end
endmodule
